//--- core/gpp_port.sv
// Purpose: one gpio port with pin mode, data, set and clear registers
// Assumes: pins synchronous to clk after the two-stage capture below
// Notes:   PINS pins per port, port 0 index is this instance; debug on 4/5
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "gpp_cfg.svh"
module gpp_port
  import gpp_pkg::*;
#(
  parameter int PINS = 8,
  parameter int NPER = 23
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [PINS-1:0]   pin_in,
  output logic      [PINS-1:0]   pin_out,
  output logic      [PINS-1:0]   pin_oe,
  output logic      [PINS-1:0]   pin_pull_up,
  output logic      [PINS-1:0]   pin_pull_down,
  output logic      [PINS-1:0]   pin_analog,
  input  wire logic [NPER-1:0]   periph_out,
  input  wire logic [NPER-1:0]   periph_oe,
  output logic      [NPER-1:0]   periph_in,
  output logic      [NPER-1:0]   periph_in_valid,
  input  wire logic              dbg_clk_out,
  input  wire logic              dbg_dio_out,
  input  wire logic              dbg_dio_oe,
  output logic                   dbg_clk_in,
  output logic                   dbg_dio_in,
  output logic      [2:0]        quad_phase_a_inputs,
  output logic      [2:0]        quad_phase_b_inputs
);
  localparam int PAIRS = PINS / 2;
  localparam int QW    = (PAIRS > 1) ? $clog2(PAIRS) : 1;

  initial begin
    if (PINS < 6 || PINS > 16 || (PINS % 2) != 0)
      $error("gpp_port: PINS must be even, 6 to 16");
    if (NPER < 1 || NPER > 31)
      $error("gpp_port: NPER must be 1 to 31");
    // ids above the top function id are never decoded
    if (NPER > 32'(`GPP_PID_MAX) + 1)
      $error("gpp_port: NPER exceeds the function id range");
    // each decoder channel owns a four-bit pair select field
    if (QW > 4)
      $error("gpp_port: pair select wider than its field");
  end

  // reset release
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // pin synchronizer
  logic [PINS-1:0] sync1_reg;
  logic [PINS-1:0] pin_s_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      pin_s_reg <= '0;
    end else begin
      sync1_reg <= pin_in;
      pin_s_reg <= sync1_reg;
    end
  end

  // register state
  logic [15:0]     mode_reg  [PINS];
  logic [15:0]     mode_next [PINS];
  logic [PINS-1:0] data_reg;
  logic [PINS-1:0] data_next;
  logic [31:0]     ctrl_reg;
  logic [31:0]     ctrl_next;
  logic [31:0]     qsel_reg;
  logic [31:0]     qsel_next;
  logic [31:0]     rdat_next;
  logic            ack_next;
  logic [31:0]     wmask;
  logic            req;
  logic            wr;

  // pin decode
  gpp_pid_t        peripheral_function_id     [PINS];
  gpp_dir_t        dir     [PINS];
  logic [PINS-1:0] analog;
  logic [PINS-1:0] pin_rd;
  logic [PINS-1:0] out_next;
  logic [PINS-1:0] oe_next;
  logic [PINS-1:0] pu_next;
  logic [PINS-1:0] pd_next;
  logic [NPER-1:0] pin_next;
  logic [NPER-1:0] pval_next;
  logic            dbg_en;
  logic [2:0][QW-1:0] qsel;
  logic            dbg_clk_next;
  logic            dbg_dio_next;
  logic [2:0]      qa_next;
  logic [2:0]      qb_next;

  // ack is blocked while high, so a held request is taken every other cycle

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr  = req && wb_we_i;

  always_comb begin
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    data_next = data_reg;
    ctrl_next = ctrl_reg;
    qsel_next = qsel_reg;
    for (int i = 0; i < PINS; i++)
      mode_next[i] = mode_reg[i];
    ack_next  = req;
    rdat_next = 32'h0000_0000;
    if (wr) begin
      unique case (wb_adr_i)
        `GPP_OFF_DATA: data_next = (data_reg & ~wmask[PINS-1:0])
                                   | (wb_dat_i[PINS-1:0] & wmask[PINS-1:0]);
        `GPP_OFF_SET:  data_next = data_reg | (wb_dat_i[PINS-1:0] & wmask[PINS-1:0]);
        `GPP_OFF_CLR:  data_next = data_reg & ~(wb_dat_i[PINS-1:0] & wmask[PINS-1:0]);
        `GPP_OFF_CTRL: ctrl_next = (ctrl_reg & ~wmask) | (wb_dat_i & wmask);
        `GPP_OFF_QSEL: qsel_next = (qsel_reg & ~wmask) | (wb_dat_i & wmask);
        default: begin
          for (int i = 0; i < PINS; i++)
            if (wb_adr_i == 8'(`GPP_OFF_MODE + 4 * i))
              mode_next[i] = (mode_reg[i] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        end
      endcase
    end else if (req) begin
      unique case (wb_adr_i)
        `GPP_OFF_DATA: rdat_next = 32'(pin_rd);
        `GPP_OFF_CTRL: rdat_next = ctrl_reg;
        `GPP_OFF_QSEL: rdat_next = qsel_reg;
        default: begin
          for (int i = 0; i < PINS; i++)
            if (wb_adr_i == 8'(`GPP_OFF_MODE + 4 * i))
              rdat_next = {16'h0000, mode_reg[i]};
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= '0;
      ctrl_reg <= `GPP_CTRL_RST;
      qsel_reg <= `GPP_QSEL_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      for (int i = 0; i < PINS; i++)
        mode_reg[i] <= `GPP_MODE_RST;
    end else begin
      data_reg <= data_next;
      ctrl_reg <= ctrl_next;
      qsel_reg <= qsel_next;
      wb_ack_o <= ack_next;
      wb_dat_o <= rdat_next;
      for (int i = 0; i < PINS; i++)
        mode_reg[i] <= mode_next[i];
    end
  end

  assign dbg_en = ctrl_reg[0];
  for (genvar c = 0; c < 3; c++) begin : g_qs
    assign qsel[c] = qsel_reg[c*4 +: QW];
  end

  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      peripheral_function_id[i]    = mode_reg[i][`GPP_PID_MSB:`GPP_PID_LSB];
      dir[i]    = gpp_dir_t'(mode_reg[i][`GPP_DIR_MSB:`GPP_DIR_LSB]);
      analog[i] = (i < 4) && (peripheral_function_id[i] == `GPP_PID_ADC);
      pin_rd[i] = analog[i] ? 1'b0 : pin_s_reg[i];
      oe_next[i]  = (dir[i] == GPP_DIR_OUT) && !analog[i];
      out_next[i] = 1'b0;
      if (peripheral_function_id[i] == `GPP_PID_GPIO)
        out_next[i] = data_reg[i];
      else if (peripheral_function_id[i] <= `GPP_PID_MAX && 32'(peripheral_function_id[i]) < NPER) begin
        out_next[i] = periph_out[peripheral_function_id[i]];
        oe_next[i]  = oe_next[i] || periph_oe[peripheral_function_id[i]];
      end
      pu_next[i] = (dir[i] == GPP_DIR_IN_PU) && !analog[i];
      pd_next[i] = (dir[i] == GPP_DIR_IN_PD) && !analog[i];
    end
    if (dbg_en) begin
      out_next[`GPP_DBG_CLK_PIN] = 1'b0;
      oe_next[`GPP_DBG_CLK_PIN]  = 1'b0;
      pu_next[`GPP_DBG_CLK_PIN]  = 1'b0;
      pd_next[`GPP_DBG_CLK_PIN]  = 1'b0;
      out_next[`GPP_DBG_DIO_PIN] = dbg_dio_out;
      oe_next[`GPP_DBG_DIO_PIN]  = dbg_dio_oe;
      pu_next[`GPP_DBG_DIO_PIN]  = !dbg_dio_oe;
      pd_next[`GPP_DBG_DIO_PIN]  = 1'b0;
    end
    // scan from the top so the lowest mapped pin is written last
    pin_next  = '0;
    pval_next = '0;
    for (int i = PINS - 1; i >= 0; i--) begin
      if (peripheral_function_id[i] != `GPP_PID_GPIO && 32'(peripheral_function_id[i]) < NPER && !analog[i]) begin
        pin_next[peripheral_function_id[i]]  = pin_s_reg[i];
        pval_next[peripheral_function_id[i]] = 1'b1;
      end
    end
  end

  // debug and decoder taps read the synchronized pins directly
  always_comb begin
    dbg_clk_next = dbg_en & pin_s_reg[`GPP_DBG_CLK_PIN];
    dbg_dio_next = dbg_en & pin_s_reg[`GPP_DBG_DIO_PIN];
    for (int c = 0; c < 3; c++) begin
      // a select past the last pair reads zero, never out of range
      qa_next[c] = 1'b0;
      qb_next[c] = 1'b0;
      if (32'(qsel[c]) < PAIRS) begin
        qa_next[c] = pin_s_reg[2 * 32'(qsel[c])];
        qb_next[c] = pin_s_reg[2 * 32'(qsel[c]) + 1];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out             <= '0;
      pin_oe              <= '0;
      pin_pull_up         <= '0;
      pin_pull_down       <= '0;
      pin_analog          <= '0;
      periph_in           <= '0;
      periph_in_valid     <= '0;
      dbg_clk_in          <= 1'b0;
      dbg_dio_in          <= 1'b0;
      quad_phase_a_inputs <= '0;
      quad_phase_b_inputs <= '0;
    end else begin
      pin_out         <= out_next;
      pin_oe          <= oe_next;
      pin_pull_up     <= pu_next;
      pin_pull_down   <= pd_next;
      pin_analog      <= analog;
      periph_in       <= pin_next;
      periph_in_valid <= pval_next;
      dbg_clk_in          <= dbg_clk_next;
      dbg_dio_in          <= dbg_dio_next;
      quad_phase_a_inputs <= qa_next;
      quad_phase_b_inputs <= qb_next;
    end
  end
endmodule

//--- inc/gpp_cfg.svh
// Purpose: offsets, field positions and reset values of the port pin block
// Assumes: classic wishbone, 32-bit words, byte addresses
// Notes:   mode registers sit one word apiece from the mode base
`ifndef GPP_CFG_SVH
`define GPP_CFG_SVH
`define GPP_ADR_W          8
`define GPP_OFF_DATA       8'h00
`define GPP_OFF_SET        8'h04
`define GPP_OFF_CLR        8'h08
`define GPP_OFF_CTRL       8'h0c
`define GPP_OFF_QSEL       8'h10
`define GPP_OFF_MODE       8'h40
`define GPP_PID_LSB        0
`define GPP_PID_MSB        4
`define GPP_DIR_LSB        8
`define GPP_DIR_MSB        9
`define GPP_MODE_RST       16'h0000
`define GPP_DATA_RST       16'h0000
`define GPP_CTRL_RST       32'h0000_0001
`define GPP_QSEL_RST       32'h0000_0000
`define GPP_PID_GPIO       5'h00
`define GPP_PID_ADC        5'h01
`define GPP_PID_MAX        5'h16
`define GPP_DBG_CLK_PIN    4
`define GPP_DBG_DIO_PIN    5
`endif

//--- inc/gpp_pkg.sv
// Purpose: types of the port pin block
// Assumes: nothing beyond the cfg header
// Notes:   direction codes follow the two-bit mode field
package gpp_pkg;
  typedef enum logic [1:0] {
    GPP_DIR_IN     = 2'h0,
    GPP_DIR_IN_PU  = 2'h1,
    GPP_DIR_IN_PD  = 2'h2,
    GPP_DIR_OUT    = 2'h3
  } gpp_dir_t;
  typedef logic [4:0] gpp_pid_t;
endpackage

//--- test/gpio_port_pin_control_tb.sv
// Purpose: register-driven bench of the pin block
// Assumes: pins settle within 6 cycles
// Notes:   model loops pin drive back to pin levels
`timescale 1ns/1ps
module gpio_port_pin_control_tb;
  logic        clk = 1'b0, nrst = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, got;
  logic        wb_ack_o, dbg_clk_in, dbg_dio_in;
  logic [7:0]  pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down, pin_analog;
  logic [22:0] periph_out = 23'h0, periph_oe = 23'h0, periph_in, periph_in_valid;
  logic [2:0]  quad_phase_a_inputs, quad_phase_b_inputs;
  int          err_total = 0;
  int          compares = 0;
  initial forever #2 clk = ~clk;
  gpp_port dut (.clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf),
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_in, .pin_out, .pin_oe, .pin_pull_up,
    .pin_pull_down, .pin_analog, .periph_out, .periph_oe, .periph_in, .periph_in_valid,
    .dbg_clk_out(1'b0), .dbg_dio_out(1'b0), .dbg_dio_oe(1'b0), .dbg_clk_in, .dbg_dio_in,
    .quad_phase_a_inputs, .quad_phase_b_inputs);
  gpp_pin_model u_pins (.clk, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down, .pin_in);
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) err_total++;
    got = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic settle;
    repeat (6) @(negedge clk);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #40000;
    err_total++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    wb(0, 8'h0c, 0); cmp(got, 32'h1);
    wb(0, 8'h44, 0); cmp(got, 32'h0);
    settle(); cmp(dbg_dio_in, 1'b1);
    for (int i = 0; i < 4; i++) wb(1, 8'h40 + 8'(4 * i), 32'h300);
    wb(1, 8'h00, 32'h0a); settle(); cmp({pin_oe[3:0], pin_out[3:0]}, 8'hfa);
    wb(1, 8'h04, 32'h05); settle(); cmp(pin_out[3:0], 4'hf);
    wb(1, 8'h08, 32'h03); settle(); cmp(pin_out[3:0], 4'hc);
    wb(1, 8'h58, 32'h102);
    wb(1, 8'h5c, 32'h202); settle();
    cmp({pin_pull_up[7:6], pin_pull_down[7:6]}, 4'h6);
    cmp(pin_pull_up[3:0] | pin_pull_down[3:0], 4'h0);
    cmp(periph_in[2], 1'b1);
    cmp(periph_in_valid[2], 1'b1);
    wb(0, 8'h00, 0); cmp(got & 32'hcf, 32'h4c);
    wb(1, 8'h10, 32'h3); settle(); cmp({quad_phase_a_inputs[0], quad_phase_b_inputs[0]}, 2'b10);
    wb(1, 8'h58, 32'h202);
    wb(1, 8'h5c, 32'h102); settle();
    cmp(periph_in[2], 1'b0);
    cmp({quad_phase_a_inputs[0], quad_phase_b_inputs[0]}, 2'b01);
    wb(1, 8'h48, 32'h303);
    wb(1, 8'h4c, 32'h303);
    periph_out[3] <= 1'b1;
    periph_oe[3] <= 1'b1;
    settle(); cmp(pin_out[3:2], 2'b11);
    periph_out[3] <= 1'b0;
    settle(); cmp(pin_out[3:0], 4'h0);
    wb(1, 8'h04, 32'h1);
    wb(1, 8'h40, 32'h101); settle(); cmp({pin_analog[0], pin_pull_up[0]}, 2'b10);
    wb(0, 8'h00, 0); cmp(got[0], 1'b0);
    wb(1, 8'h58, 32'h001); settle(); cmp(pin_analog[6], 1'b0);
    wb(0, 8'h58, 0); cmp(got, 32'h1);
    wb(1, 8'h0c, 0); settle(); cmp(dbg_dio_in, 1'b0);
    cmp(dbg_clk_in, 1'b0);
    wb(0, 8'h04, 0); cmp(got, 32'h0);
    wb(1, 8'h20, 32'hff);
    wb(0, 8'h20, 0); cmp(got, 32'h0);
    end_sim();
  end
endmodule

//--- test/gpp_pin_model.sv
// Purpose: board side of the pins
// Assumes: no outside driver
// Notes:   floating pins toggle each cycle
`timescale 1ns/1ps
module gpp_pin_model #(
  parameter int PINS = 8
) (
  input wire logic            clk,
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe,
  input wire logic [PINS-1:0] pin_pull_up,
  input wire logic [PINS-1:0] pin_pull_down,
  output logic     [PINS-1:0] pin_in
);
  logic float_reg = 1'b0;
  always @(posedge clk) float_reg <= !float_reg;
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (pin_pull_up[i]) pin_in[i] = 1'b1;
      else if (pin_pull_down[i]) pin_in[i] = 1'b0;
      else pin_in[i] = float_reg;
    end
  end
endmodule

//--- test/gpp_port_chk.sv
// Purpose: port-level checks of the pin block
// Assumes: ack one cycle after take
// Notes:   bound to every gpp_port
`timescale 1ns/1ps
module gpp_port_chk #(
  parameter int PINS = 8,
  parameter int NPER = 23
) (
  input wire logic            clk,
  input wire logic            nrst,
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_we_i,
  input wire logic [7:0]      wb_adr_i,
  input wire logic [31:0]     wb_dat_o,
  input wire logic            wb_ack_o,
  input wire logic [PINS-1:0] pin_pull_up,
  input wire logic [PINS-1:0] pin_pull_down,
  input wire logic [PINS-1:0] pin_analog
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_ACK_TAKE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_QUIET: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  AST_PULL_EXCL: assert property ((pin_pull_up & pin_pull_down) == '0)
    else $error("both pulls on");
  AST_ANALOG_NOPULL: assert property (((pin_pull_up | pin_pull_down) & pin_analog) == '0)
    else $error("pull on analog pin");
  AST_ANALOG_PINS: assert property ((pin_analog >> 4) == '0)
    else $error("analog above pin 3");
  AST_WO_READ: assert property (wb_ack_o && !wb_we_i && wb_adr_i inside {8'h04, 8'h08}
    |-> wb_dat_o == 32'h0) else $error("set or clear read not zero");
  AST_UNMAPPED: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h20
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
endmodule
bind gpp_port gpp_port_chk #(.PINS(PINS), .NPER(NPER)) u_chk (.clk, .nrst, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .pin_pull_up, .pin_pull_down,
  .pin_analog);
